/* logic/spih_pkg.sv */
// Constants shared by the serial port host controller
`default_nettype none
package spih_pkg;
    // Register byte offsets on the APB side
    localparam logic [7:0] SPIH_CTRL_OFS   = 8'h00;
    localparam logic [7:0] SPIH_DIV_OFS    = 8'h04;
    localparam logic [7:0] SPIH_DATA_OFS   = 8'h08;
    localparam logic [7:0] SPIH_STATUS_OFS = 8'h0c;
    localparam logic [7:0] SPIH_SELECT_OFS = 8'h10;
    // Control register fields
    localparam int SPIH_CTRL_EN_BIT   = 0;
    localparam int SPIH_CTRL_CPOL_BIT = 1;
    localparam int SPIH_CTRL_CKE_BIT  = 2;
    localparam int SPIH_CTRL_SMP_BIT  = 3;
    localparam int SPIH_CTRL_HOLD_BIT = 4;
    // Status register fields
    localparam int SPIH_STAT_BUSY_BIT = 0;
    localparam int SPIH_STAT_FULL_BIT = 1;
    localparam int SPIH_STAT_WRITE_COLLISION_FLAG_BIT = 2;
    // Reset values
    localparam logic [4:0] SPIH_CTRL_RST = 5'h00;
    localparam logic [7:0] SPIH_DIV_RST  = 8'h04;
    // Serial frame geometry
    localparam int SPIH_BYTE_BITS  = 8;
    localparam int SPIH_EDGE_COUNT = 2 * SPIH_BYTE_BITS;
    // Sequencer states
    typedef enum logic [3:0] {
        SPIH_ST_IDLE = 4'b0001,
        SPIH_ST_LEAD = 4'b0010,
        SPIH_ST_RUN  = 4'b0100,
        SPIH_ST_TAIL = 4'b1000
    } spih_state_e;
endpackage
`default_nettype wire

/* logic/spih_host.sv */
// Serial port host: drives a synchronous serial client over its pins
`default_nettype none
module spih_host
    import spih_pkg::*;
#(
    parameter int N_CS = 4
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // APB slave
    input  wire logic [7:0]        paddr_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Serial pins
    output logic                   sck_o,
    output logic                   mosi_o,
    input  wire logic              miso_i,
    output logic      [N_CS-1:0]   cs_n_o
);
    localparam int CS_W = (N_CS > 1) ? $clog2(N_CS) : 1;
    localparam logic [3:0] LAST_EDGE = 4'(SPIH_EDGE_COUNT - 1);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    spih_state_e           state_q;
    logic [4:0]            ctrl_q;
    logic [7:0]            div_q;
    logic [CS_W-1:0]       sel_q;
    logic [CS_W-1:0]       sel_act_q;
    logic                  cs_act_q;
    logic [7:0]            sr_q;
    logic [7:0]            rx_q;
    logic                  full_q;
    logic                  write_collision_flag_q;
    logic                  cap_q;
    logic                  pend_q;
    logic [7:0]            cnt_q;
    logic [3:0]            edge_q;
    logic                  miso_meta_q;
    logic                  miso_s_q;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire acc_first = psel_i & penable_i & ~pready_o;
    wire acc_done  = psel_i & penable_i & pready_o;
    wire wr_done   = acc_done & pwrite_i;
    wire rd_done   = acc_done & ~pwrite_i;
    wire hit_ctrl  = (paddr_i == SPIH_CTRL_OFS);
    wire hit_div   = (paddr_i == SPIH_DIV_OFS);
    wire hit_data  = (paddr_i == SPIH_DATA_OFS);
    wire hit_stat  = (paddr_i == SPIH_STATUS_OFS);
    wire hit_sel   = (paddr_i == SPIH_SELECT_OFS);
    wire mapped    = hit_ctrl | hit_div | hit_data | hit_stat | hit_sel;

    wire en    = ctrl_q[SPIH_CTRL_EN_BIT];
    wire cpol  = ctrl_q[SPIH_CTRL_CPOL_BIT];
    wire cke   = ctrl_q[SPIH_CTRL_CKE_BIT];
    wire input_sample_phase   = ctrl_q[SPIH_CTRL_SMP_BIT];
    wire hold  = ctrl_q[SPIH_CTRL_HOLD_BIT];
    wire busy  = (state_q != SPIH_ST_IDLE);

    wire data_wr   = wr_done & hit_data;
    // Write while shifting or with collision pending is dropped
    wire wr_reject = data_wr & en & (busy | write_collision_flag_q);
    wire start     = data_wr & en & ~busy & ~write_collision_flag_q;
    wire write_collision_flag_clr  = wr_done & hit_stat & pwdata_i[SPIH_STAT_WRITE_COLLISION_FLAG_BIT];

    wire [31:0] rd_ctrl = {27'h0, ctrl_q};
    wire [31:0] rd_div  = {24'h0, div_q};
    wire [31:0] rd_data = {24'h0, rx_q};
    wire [31:0] rd_stat = {29'h0, write_collision_flag_q, full_q, busy};
    wire [31:0] rd_sel  = {{(32 - CS_W){1'b0}}, sel_q};
    wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                          hit_div  ? rd_div  :
                          hit_data ? rd_data :
                          hit_stat ? rd_stat :
                          hit_sel  ? rd_sel  : 32'h0;

    // Control configuration only changes while disabled
    wire [4:0] ctrl_wr  = en ? {ctrl_q[4:1], pwdata_i[SPIH_CTRL_EN_BIT]}
                             : pwdata_i[4:0];

    ////////////////////////////////////////////////////////////////////////
    // Bit timing
    wire tick        = busy & (cnt_q == div_q);
    wire launch_edge = cke ? edge_q[0] : ~edge_q[0];
    wire bit_now     = (pend_q & input_sample_phase) ? miso_s_q : cap_q;
    wire [7:0] sr_shift = {sr_q[6:0], bit_now};
    wire first_launch = (edge_q == 4'h0);
    wire last_edge    = (edge_q == LAST_EDGE);
    // With edge clear the final sampled bit still has to be shifted in
    wire [7:0] rx_fin  = cke ? sr_q : sr_shift;
    wire byte_done     = tick & (state_q == SPIH_ST_TAIL);
    wire cs_drop       = ~en | (~busy & ~hold & ~start);

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= acc_first;
            pslverr_o <= acc_first & ~mapped;
            if (acc_first && !pwrite_i) begin
                prdata_o <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= SPIH_CTRL_RST;
            div_q  <= SPIH_DIV_RST;
            sel_q  <= '0;
        end else if (wr_done) begin
            if (hit_ctrl) begin
                ctrl_q <= ctrl_wr;
            end
            if (hit_div && !en) begin
                div_q <= pwdata_i[7:0];
            end
            if (hit_sel) begin
                sel_q <= pwdata_i[CS_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: a hardware set wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            full_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            rx_q   <= 8'h00;
        end else begin
            if (byte_done) begin
                rx_q   <= rx_fin;
                full_q <= 1'b1;
            end else if (rd_done && hit_data) begin
                full_q <= 1'b0;
            end
            if (wr_reject) begin
                write_collision_flag_q <= 1'b1;
            end else if (write_collision_flag_clr) begin
                write_collision_flag_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser for the client data line
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            miso_meta_q <= 1'b0;
            miso_s_q    <= 1'b0;
        end else begin
            miso_meta_q <= miso_i;
            miso_s_q    <= miso_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Half-period counter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 8'h00;
        end else if (!busy || tick) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= SPIH_ST_IDLE;
            edge_q  <= 4'h0;
        end else if (!en) begin
            state_q <= SPIH_ST_IDLE;
            edge_q  <= 4'h0;
        end else begin
            case (state_q)
                SPIH_ST_IDLE: begin
                    edge_q <= 4'h0;
                    if (start) begin
                        state_q <= SPIH_ST_LEAD;
                    end
                end
                SPIH_ST_LEAD: begin
                    if (tick) begin
                        state_q <= SPIH_ST_RUN;
                    end
                end
                SPIH_ST_RUN: begin
                    if (tick) begin
                        edge_q <= edge_q + 4'h1;
                        if (last_edge) begin
                            state_q <= SPIH_ST_TAIL;
                        end
                    end
                end
                SPIH_ST_TAIL: begin
                    if (tick) begin
                        state_q <= SPIH_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= SPIH_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift register and capture
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sr_q   <= 8'h00;
            cap_q  <= 1'b0;
            pend_q <= 1'b0;
        end else if (start) begin
            sr_q   <= pwdata_i[7:0];
            pend_q <= 1'b0;
        end else if (tick && state_q == SPIH_ST_RUN) begin
            if (launch_edge) begin
                if (!first_launch) begin
                    sr_q <= sr_shift;
                end
                pend_q <= 1'b0;
                if (pend_q && input_sample_phase) begin
                    cap_q <= miso_s_q;
                end
            end else begin
                pend_q <= input_sample_phase;
                if (!input_sample_phase) begin
                    cap_q <= miso_s_q;
                end
            end
        end else if (tick) begin
            pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_o <= 1'b0;
            mosi_o <= 1'b0;
        end else if (state_q != SPIH_ST_RUN) begin
            sck_o <= cpol;
            if (state_q == SPIH_ST_LEAD) begin
                mosi_o <= sr_q[7];
            end
        end else if (tick) begin
            sck_o <= ~sck_o;
            if (launch_edge) begin
                mosi_o <= first_launch ? sr_q[7] : sr_q[6];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_act_q  <= 1'b0;
            sel_act_q <= '0;
        end else if (start) begin
            cs_act_q  <= 1'b1;
            sel_act_q <= cs_act_q ? sel_act_q : sel_q;
        end else if (cs_drop) begin
            cs_act_q  <= 1'b0;
        end
    end

    // One active-low select per client, never more than one low
    wire [N_CS-1:0] cs_n_d;
    for (genvar i = 0; i < N_CS; i++) begin : g_cs
        assign cs_n_d[i] = ~(cs_act_q & (sel_act_q == CS_W'(i)));
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_n_o <= '1;
        end else begin
            cs_n_o <= cs_n_d;
        end
    end

endmodule
`default_nettype wire

/* sim/spih_monitor.sv */
// Port assertions for the serial port host controller
`default_nettype none
module spih_monitor
    import spih_pkg::*;
#(
    parameter int N_CS = 4
) (
    // Clock and reset
    input wire logic            clk_i,
    input wire logic            arst_n_i,
    // APB
    input wire logic [7:0]      paddr_i,
    input wire logic            psel_i,
    input wire logic            penable_i,
    input wire logic            pwrite_i,
    input wire logic [31:0]     pwdata_i,
    input wire logic            pready_o,
    input wire logic            pslverr_o,
    // Serial pins
    input wire logic            sck_o,
    input wire logic            mosi_o,
    input wire logic [N_CS-1:0] cs_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] ctrl_q;
    logic       cpol_q;
    logic       sck_q;
    logic [3:0] tog_q;
    wire        done_w  = psel_i & penable_i & pready_o;
    wire        wctl_w  = done_w & pwrite_i & (paddr_i == SPIH_CTRL_OFS);
    wire        idle_w  = &cs_n_o;
    wire        cap_w   = (sck_o != sck_q) & !idle_w &
                          ((sck_o != ctrl_q[1]) == ctrl_q[2]);
    wire        map_w   = paddr_i inside {SPIH_CTRL_OFS, SPIH_DIV_OFS,
                          SPIH_DATA_OFS, SPIH_STATUS_OFS, SPIH_SELECT_OFS};
    // Config bits follow writes only while the port is off
    wire [4:0]  ctrl_d  = ctrl_q[0] ? {ctrl_q[4:1], pwdata_i[0]}
                                    : pwdata_i[4:0];
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= SPIH_CTRL_RST;
            cpol_q <= 1'b0;
            sck_q  <= 1'b0;
            tog_q  <= 4'h0;
        end else begin
            ctrl_q <= wctl_w ? ctrl_d : ctrl_q;
            cpol_q <= ctrl_q[1];
            sck_q  <= sck_o;
            tog_q  <= idle_w ? 4'h0 : tog_q + 4'(sck_o != sck_q);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_first_access;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_answer;
        pready_o ##1 !pready_o;
    endsequence
    apb_wait_a: assert property (s_first_access |=> s_answer)
        else $error("ready not one cycle after first access");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    unmapped_err_a: assert property (done_w |-> pslverr_o == !map_w)
        else $error("error flag does not match address map");
    one_select_a: assert property ($onehot0(~cs_n_o))
        else $error("more than one select low");
    sck_idle_a: assert property (idle_w[*4] |-> sck_o == cpol_q)
        else $error("serial clock not at idle level");
    sck_sel_a: assert property (sck_o != cpol_q |-> !idle_w)
        else $error("serial clock active with no select");
    byte_group_a: assert property ($rose(idle_w) |-> tog_q == 4'h0)
        else $error("clock edges not a multiple of one byte");
    mosi_hold_a: assert property (cap_w |->
        $stable(mosi_o) ##1 $stable(mosi_o))
        else $error("data out moved at capture edge");
endmodule
bind spih_host spih_monitor #(.N_CS(N_CS)) u_mon (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sck_o(sck_o),
    .mosi_o(mosi_o), .cs_n_o(cs_n_o));
`default_nettype wire

/* sim/spih_client_model.sv */
// Behavioural serial client on one select line
`default_nettype none
module spih_client_model (
    // Serial pins
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       cs_n_i,
    output wire logic       miso_o,
    // Bench side
    input  wire logic       cpol_i,
    input  wire logic       cke_i,
    input  wire logic [7:0] tx_i,
    output var  logic [7:0] rx_o,
    output var  logic [7:0] count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sr = 8'h00;
    logic [2:0] bits = 3'h0;
    logic       out = 1'b0;
    initial rx_o = 8'h00;
    initial count_o = 8'h00;
    // Released line shows the inverse of the last bit
    assign miso_o = cs_n_i ? ~out : out;
    always @(negedge cs_n_i) begin
        sr = tx_i;
        out = tx_i[7];
        bits = 3'h0;
    end
    always @(sck_i) begin
        if (cs_n_i === 1'b0) begin
            if ((sck_i !== cpol_i) == cke_i) begin
                sr = {sr[6:0], mosi_i};
                bits = bits + 3'h1;
                if (bits == 3'h0) begin
                    rx_o = sr;
                    count_o = count_o + 8'h01;
                    sr = tx_i;
                end
            end else begin
                out = sr[7];
            end
        end
    end
endmodule
`default_nettype wire

/* sim/tb_spi_host_client_shift_port.sv */
// Self-checking bench for the serial port host controller
`default_nettype none
module tb_spi_host_client_shift_port
    import spih_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic        sck, mosi, miso, err, m_cpol, m_cke;
    logic [7:0]  paddr, m_tx, m_rx, m_cnt, nb;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  cs_n;
    int          fail_count, checks_done;
    always #25 clk = ~clk;
    spih_host #(.N_CS(4)) DUT (.clk_i(clk), .arst_n_i(arst_n),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sck_o(sck),
        .mosi_o(mosi), .miso_i(miso), .cs_n_o(cs_n));
    spih_client_model u_cli (.sck_i(sck), .mosi_i(mosi),
        .cs_n_i(cs_n[1]), .miso_o(miso), .cpol_i(m_cpol), .cke_i(m_cke),
        .tx_i(m_tx), .rx_o(m_rx), .count_o(m_cnt));
    task automatic give_verdict;
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
            give_verdict();
        end
    endtask
    task automatic rdchk(string n, logic [7:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 100 && rd[0] !== 1'b0; k++)
            apb(1'b0, SPIH_STATUS_OFS, 32'h0);
        if (rd[0] !== 1'b0) begin
            chk("busy", 32'h0, rd);
            give_verdict();
        end
    endtask
    task automatic xfer(logic [7:0] b);
        apb(1'b1, SPIH_DATA_OFS, {24'h0, b});
        nb = nb + 8'h01;
        rd = 32'h1;
        wait_idle();
        chk("rx", {24'h0, b}, {24'h0, m_rx});
        chk("count", {24'h0, nb}, {24'h0, m_cnt});
        rdchk("status", SPIH_STATUS_OFS, 32'h2);
        rdchk("data", SPIH_DATA_OFS, {24'h0, m_tx});
        rdchk("status", SPIH_STATUS_OFS, 32'h0);
    endtask
    initial begin
        {clk, arst_n, psel, penable, pwrite, m_cpol, m_cke} = 7'h00;
        {paddr, pwdata, m_tx, nb, fail_count, checks_done} = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rdchk("ctrl", SPIH_CTRL_OFS, {27'h0, SPIH_CTRL_RST});
        rdchk("div", SPIH_DIV_OFS, {24'h0, SPIH_DIV_RST});
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        apb(1'b1, SPIH_DIV_OFS, 32'h3);
        rdchk("div", SPIH_DIV_OFS, 32'h3);
        apb(1'b1, SPIH_SELECT_OFS, 32'h1);
        for (int i = 0; i < 8; i++) begin
            m_cpol <= i[0];
            m_cke <= i[1];
            m_tx <= 8'h3c ^ 8'(i);
            apb(1'b1, SPIH_CTRL_OFS, 32'(i * 2));
            apb(1'b1, SPIH_CTRL_OFS, 32'(i * 2 + 1));
            xfer(8'ha5 ^ 8'(i * 17));
            chk("select", 32'hf, {28'h0, cs_n});
            apb(1'b1, SPIH_CTRL_OFS, 32'(i * 2));
        end
        apb(1'b1, SPIH_CTRL_OFS, 32'hf);
        apb(1'b1, SPIH_CTRL_OFS, 32'h1);
        rdchk("ctrl", SPIH_CTRL_OFS, 32'hf);
        apb(1'b1, SPIH_DATA_OFS, 32'h81);
        apb(1'b1, SPIH_DATA_OFS, 32'h7e);
        nb = nb + 8'h01;
        rd = 32'h1;
        wait_idle();
        chk("rx", 32'h81, {24'h0, m_rx});
        rdchk("status", SPIH_STATUS_OFS, 32'h6);
        apb(1'b1, SPIH_DATA_OFS, 32'h55);
        rdchk("status", SPIH_STATUS_OFS, 32'h6);
        chk("count", {24'h0, nb}, {24'h0, m_cnt});
        rdchk("data", SPIH_DATA_OFS, {24'h0, m_tx});
        apb(1'b1, SPIH_STATUS_OFS, 32'h7);
        rdchk("status", SPIH_STATUS_OFS, 32'h0);
        apb(1'b1, SPIH_CTRL_OFS, 32'h0);
        apb(1'b1, SPIH_CTRL_OFS, 32'h1e);
        apb(1'b1, SPIH_CTRL_OFS, 32'h1f);
        xfer(8'hc3);
        chk("select", 32'hd, {28'h0, cs_n});
        apb(1'b1, SPIH_CTRL_OFS, 32'h0);
        apb(1'b1, SPIH_DATA_OFS, 32'h99);
        rdchk("status", SPIH_STATUS_OFS, 32'h0);
        chk("select", 32'hf, {28'h0, cs_n});
        chk("count", {24'h0, nb}, {24'h0, m_cnt});
        give_verdict();
    end
endmodule
`default_nettype wire
